// *** dv/gpf_board_model.sv ***
`timescale 1ns/1ps
module gpf_board_model
(
   input wire logic clk,
   input wire gpf_pkg::gpf_pad_t pad,
   input wire logic [18:0] ext_en,
   input wire logic [18:0] ext_val,
   output logic [18:0] pin_in
);
   import gpf_pkg::*;
   // Undriven, unpulled pins toggle so a stale level never passes for a real one
   logic [18:0] float_reg = 19'h2aaaa;
   always_ff @(posedge clk)
   begin
      float_reg <= ~float_reg;
   end
   assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_en & ext_val)
      | (~pad.oe & ~ext_en & pad.pull_en & pad.pull_up)
      | (~pad.oe & ~ext_en & ~pad.pull_en & float_reg);
endmodule

// *** dv/gpf_gpio_assertions.sv ***
`timescale 1ns/1ps
module gpf_gpio_assertions
(
   input wire logic clk,
   input wire logic reset,
   input wire gpf_pkg::gpf_bus_req_t bus_req,
   input wire logic [31:0] rdata,
   input wire logic [18:0] pin_in,
   input wire gpf_pkg::gpf_pad_t pad,
   input wire logic wake,
   input wire logic irq
);
   import gpf_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   wire rq = bus_req.rd;
   wire wd = bus_req.wr && bus_req.addr == GPF_DIR_OFS;
   wire wv = bus_req.wr && bus_req.addr == GPF_DRV_OFS;
   wire wp = bus_req.wr && bus_req.addr == GPF_PEN_OFS;
   a_out_needs_oe: assert property ((pad.out & ~pad.oe) == 19'h00000)
      else $error("pad driven high while not enabled");
   a_rdata_idle: assert property (!rq |=> rdata == 32'h0)
      else $error("read data outside read slot");
   a_dir_write: assert property (wd |-> ##2 pad.oe == $past(bus_req.wdata[18:0], 2))
      else $error("direction not applied");
   a_drive_write: assert property (wv |-> ##2 pad.drive_high == $past(bus_req.wdata[18:0], 2))
      else $error("drive not applied");
   a_pull_write: assert property (wp |-> ##2 pad.pull_en == $past(bus_req.wdata[18:0], 2))
      else $error("pull enable not applied");
   a_in_read: assert property (rq && bus_req.addr == GPF_IN_OFS |=>
      rdata == {13'h0000, $past(pin_in)})
      else $error("pin read wrong");
   a_clr_read: assert property (rq && bus_req.addr == GPF_ICLR_OFS |=> rdata == 32'h0)
      else $error("clear register readable");
   a_unmapped_read: assert property (rq && bus_req.addr > GPF_IEN_OFS |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   cover property (bus_req.wr && bus_req.addr == GPF_PSEL_OFS);
   cover property (wake);
   cover property (irq);
endmodule
bind gpf_gpio_top gpf_gpio_assertions u_chk
(
   .clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
   .pin_in(pin_in), .pad(pad), .wake(wake), .irq(irq)
);

// *** dv/test_gpf_gpio_top.sv ***
`timescale 1ns/1ps
module test_gpf_gpio_top;
   import gpf_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   gpf_bus_req_t bus_req = '0;
   logic [31:0] rdata;
   logic [18:0] pin_in;
   gpf_pad_t pad;
   logic wake;
   logic irq;
   logic [18:0] ext_en = 19'h7ffff;
   logic [18:0] ext_val = 19'h00000;
   logic [31:0] d;
   int fail_count = 0;
   int checked = 0;
   initial
   begin
      forever #25 clk = ~clk;
   end
   gpf_gpio_top dut
   (
      .clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
      .pin_in(pin_in), .pad(pad), .wake(wake), .irq(irq)
   );
   gpf_board_model board
   (
      .clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, e);
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Long settle lets a shrinking period flush the old count first
   task automatic cnt(input int p, input int e);
      int c = 0;
      repeat (24) @(posedge clk);
      repeat (40)
      begin
         @(posedge clk);
         #1;
         if (pad.out[p] === 1'b1)
            c++;
      end
      chk(32'(c), 32'(e));
   endtask
   task automatic close_out;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      close_out;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      settle;
      chk({29'h0, |pad, wake, irq}, 32'h0);
      rchk(GPF_PPER_OFS, 32'h14);
      rchk(GPF_SPER_OFS, 32'h14);
      rchk(GPF_SDUTA_OFS, 32'ha);
      rchk(GPF_SDUTB_OFS, 32'ha);
      rchk(GPF_PSEL_OFS, 32'h0);
      $display("test reset done");
      wr(GPF_DIR_OFS, 32'h0000f);
      wr(GPF_OUT_OFS, 32'h7fffa);
      wr(GPF_DRV_OFS, 32'h40001);
      wr(GPF_PEN_OFS, 32'h60000);
      wr(GPF_PUP_OFS, 32'h20000);
      ext_val <= 19'h55550;
      settle;
      chk({13'h0, pad.oe}, 32'h0000f);
      chk({13'h0, pad.out}, 32'h0000a);
      chk({13'h0, pad.drive_high}, 32'h40001);
      chk({13'h0, pad.pull_up}, 32'h20000);
      rchk(GPF_IN_OFS, 32'h5555a);
      rchk(8'h48, 32'h0);
      ext_en <= 19'h00000;
      rd(GPF_IN_OFS, d);
      chk(d & 32'h60000, 32'h20000);
      $display("test pins done");
      ext_en <= 19'h7ffff;
      ext_val <= 19'h00000;
      wr(GPF_DIR_OFS, 32'h0);
      // Level first, so the low pin never matches while the enable goes on
      wr(GPF_WLV_OFS, 32'h100);
      wr(GPF_WEN_OFS, 32'h100);
      wr(GPF_IEN_OFS, 32'h100);
      settle;
      chk({31'h0, irq}, 32'h0);
      ext_val <= 19'h00100;
      settle;
      chk({30'h0, wake, irq}, 32'h3);
      ext_val <= 19'h00000;
      rchk(GPF_ISTAT_OFS, 32'h100);
      wr(GPF_ICLR_OFS, 32'h100);
      settle;
      chk({30'h0, wake, irq}, 32'h0);
      rchk(GPF_ISTAT_OFS, 32'h0);
      wr(GPF_IEN_OFS, 32'h0);
      wr(GPF_WLV_OFS, 32'h0);
      settle;
      chk({30'h0, wake, irq}, 32'h2);
      rchk(GPF_ISTAT_OFS, 32'h100);
      // The level still matches, so a clear in that cycle must not win
      wr(GPF_ICLR_OFS, 32'h100);
      rchk(GPF_ISTAT_OFS, 32'h100);
      $display("test wake done");
      wr(GPF_DIR_OFS, 32'h7ffff);
      wr(GPF_OUT_OFS, 32'h0);
      wr(GPF_PSEL_OFS, 32'h1);
      cnt(0, 0);
      wr(GPF_PDUT_OFS, 32'h14);
      cnt(0, 40);
      wr(GPF_PDUT_OFS, 32'h5);
      cnt(0, 10);
      wr(GPF_PPER_OFS, 32'ha);
      cnt(0, 10);
      $display("test pwm done");
      wr(GPF_SQCFG_OFS, 32'h8a1);
      cnt(1, 20);
      wr(GPF_SPER_OFS, 32'h8);
      wr(GPF_SDUTA_OFS, 32'h2);
      wr(GPF_SDUTB_OFS, 32'h6);
      cnt(1, 10);
      cnt(2, 30);
      cnt(3, 0);
      wr(GPF_SPER_OFS, 32'h2);
      cnt(1, 16);
      wr(GPF_SPER_OFS, 32'h0);
      cnt(1, 0);
      $display("test square done");
      close_out;
   end
endmodule

// *** include/gpf_pkg.sv ***
package gpf_pkg;
   localparam int GPF_NPINS = 19;
   localparam int GPF_AW = 8;
   localparam int GPF_PW = 16;
   // Register offsets (byte addresses)
   localparam logic [7:0] GPF_DIR_OFS = 8'h00;
   localparam logic [7:0] GPF_OUT_OFS = 8'h04;
   localparam logic [7:0] GPF_IN_OFS = 8'h08;
   localparam logic [7:0] GPF_DRV_OFS = 8'h0c;
   localparam logic [7:0] GPF_PEN_OFS = 8'h10;
   localparam logic [7:0] GPF_PUP_OFS = 8'h14;
   localparam logic [7:0] GPF_WEN_OFS = 8'h18;
   localparam logic [7:0] GPF_WLV_OFS = 8'h1c;
   localparam logic [7:0] GPF_PSEL_OFS = 8'h20;
   localparam logic [7:0] GPF_SQCFG_OFS = 8'h24;
   localparam logic [7:0] GPF_PPER_OFS = 8'h28;
   localparam logic [7:0] GPF_PDUT_OFS = 8'h2c;
   localparam logic [7:0] GPF_SPER_OFS = 8'h30;
   localparam logic [7:0] GPF_SDUTA_OFS = 8'h34;
   localparam logic [7:0] GPF_SDUTB_OFS = 8'h38;
   localparam logic [7:0] GPF_ISTAT_OFS = 8'h3c;
   localparam logic [7:0] GPF_ICLR_OFS = 8'h40;
   localparam logic [7:0] GPF_IEN_OFS = 8'h44;
   // Square-wave pin config fields
   localparam int GPF_SQ_PINA_LSB = 0;
   localparam int GPF_SQ_ENA_BIT = 5;
   localparam int GPF_SQ_PINB_LSB = 6;
   localparam int GPF_SQ_ENB_BIT = 11;
   localparam int GPF_SQ_W = 12;
   // Timing
   localparam int GPF_CLK_HZ = 20_000_000;
   localparam int GPF_PWM_FMAX_HZ = 1_000_000;
   localparam int GPF_SQW_FMAX_HZ = 4_000_000;
   localparam logic [15:0] GPF_PWM_MIN_PER =
      16'((GPF_CLK_HZ + GPF_PWM_FMAX_HZ - 1) / GPF_PWM_FMAX_HZ);
   localparam logic [15:0] GPF_SQW_MIN_PER =
      16'((GPF_CLK_HZ + GPF_SQW_FMAX_HZ - 1) / GPF_SQW_FMAX_HZ);
   // Reset values
   localparam logic [18:0] GPF_PINS_RST = 19'h00000;
   localparam logic [11:0] GPF_SQCFG_RST = 12'h000;
   localparam logic [15:0] GPF_PPER_RST = 16'h0014;
   localparam logic [15:0] GPF_PDUT_RST = 16'h0000;
   localparam logic [15:0] GPF_SPER_RST = 16'h0014;
   localparam logic [15:0] GPF_SDUT_RST = 16'h000a;
   localparam logic [31:0] GPF_RDATA_RST = 32'h00000000;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } gpf_bus_req_t;

   typedef struct packed {
      logic [18:0] oe;
      logic [18:0] out;
      logic [18:0] drive_high;
      logic [18:0] pull_en;
      logic [18:0] pull_up;
   } gpf_pad_t;
endpackage

// *** rtl/gpf_gpio_top.sv ***
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module gpf_gpio_top
(
   input wire logic clk,
   input wire logic reset,
   input wire gpf_pkg::gpf_bus_req_t bus_req,
   output logic [31:0] rdata,
   input wire logic [18:0] pin_in,
   output gpf_pkg::gpf_pad_t pad,
   output logic wake,
   output logic irq
);
   import gpf_pkg::*;

   logic [18:0] dir_reg, dir_next;
   logic [18:0] out_reg, out_next;
   logic [18:0] drv_reg, drv_next;
   logic [18:0] pen_reg, pen_next;
   logic [18:0] pup_reg, pup_next;
   logic [18:0] wen_reg, wen_next;
   logic [18:0] wlv_reg, wlv_next;
   logic [18:0] psel_reg, psel_next;
   logic [11:0] sqcfg_reg, sqcfg_next;
   logic [15:0] pper_reg, pper_next;
   logic [15:0] pdut_reg, pdut_next;
   logic [15:0] sper_reg, sper_next;
   logic [15:0] sduta_reg, sduta_next;
   logic [15:0] sdutb_reg, sdutb_next;
   logic [18:0] istat_reg, istat_next;
   logic [18:0] ien_reg, ien_next;
   logic [31:0] rdata_reg, rdata_next;
   gpf_pad_t pad_reg, pad_next;
   logic wake_reg, wake_next;
   logic irq_reg, irq_next;

   logic pwm_wave;
   logic [1:0] sqw_wave;
   logic [18:0] wake_hit;
   logic [18:0] pin_drv_val;
   logic [4:0] sq_pin_a;
   logic [4:0] sq_pin_b;
   logic sq_en_a;
   logic sq_en_b;
   logic wr_hit;
   logic [18:0] wr_pins;
   logic [15:0] wr_half;

   assign sq_pin_a = sqcfg_reg[GPF_SQ_PINA_LSB +: 5];
   assign sq_pin_b = sqcfg_reg[GPF_SQ_PINB_LSB +: 5];
   assign sq_en_a = sqcfg_reg[GPF_SQ_ENA_BIT];
   assign sq_en_b = sqcfg_reg[GPF_SQ_ENB_BIT];
   assign wr_hit = bus_req.wr;
   assign wr_pins = bus_req.wdata[18:0];
   assign wr_half = bus_req.wdata[15:0];

   // One shared pulse-width generator for every pin that selects it and is not a square-wave target
   gpf_wave_gen
   #(
      .MIN_PER(GPF_PWM_MIN_PER)
   )
   u_pwm
   (
      .clk(clk),
      .reset(reset),
      .period(pper_reg),
      .duty(pdut_reg),
      .wave(pwm_wave)
   );

   // Both square-wave channels run from the same period register
   gpf_wave_gen
   #(
      .MIN_PER(GPF_SQW_MIN_PER)
   )
   u_sqw_a
   (
      .clk(clk),
      .reset(reset),
      .period(sper_reg),
      .duty(sduta_reg),
      .wave(sqw_wave[0])
   );

   gpf_wave_gen
   #(
      .MIN_PER(GPF_SQW_MIN_PER)
   )
   u_sqw_b
   (
      .clk(clk),
      .reset(reset),
      .period(sper_reg),
      .duty(sdutb_reg),
      .wave(sqw_wave[1])
   );

   // Per-pin source selection and wake detection
   genvar gi;
   generate
      for (gi = 0; gi < GPF_NPINS; gi++)
      begin : g_pin
         logic sel_a;
         logic sel_b;
         // Only two square-wave slots exist, so no third pin can take it
         assign sel_a = sq_en_a && (sq_pin_a == 5'(gi));
         assign sel_b = sq_en_b && (sq_pin_b == 5'(gi));
         assign pin_drv_val[gi] = sel_a ? sqw_wave[0] :
                                  sel_b ? sqw_wave[1] :
                                  psel_reg[gi] ? pwm_wave :
                                  out_reg[gi];
         assign wake_hit[gi] = wen_reg[gi] && (pin_in[gi] == wlv_reg[gi]);
      end
   endgenerate

   // Register writes; each field touches only its own pin bits
   always_comb
   begin
      dir_next = dir_reg;
      out_next = out_reg;
      drv_next = drv_reg;
      pen_next = pen_reg;
      pup_next = pup_reg;
      wen_next = wen_reg;
      wlv_next = wlv_reg;
      psel_next = psel_reg;
      sqcfg_next = sqcfg_reg;
      pper_next = pper_reg;
      pdut_next = pdut_reg;
      sper_next = sper_reg;
      sduta_next = sduta_reg;
      sdutb_next = sdutb_reg;
      ien_next = ien_reg;
      if (wr_hit)
      begin
         unique case (bus_req.addr)
            GPF_DIR_OFS: dir_next = wr_pins;
            GPF_OUT_OFS: out_next = wr_pins;
            GPF_DRV_OFS: drv_next = wr_pins;
            GPF_PEN_OFS: pen_next = wr_pins;
            GPF_PUP_OFS: pup_next = wr_pins;
            GPF_WEN_OFS: wen_next = wr_pins;
            GPF_WLV_OFS: wlv_next = wr_pins;
            GPF_PSEL_OFS: psel_next = wr_pins;
            GPF_SQCFG_OFS: sqcfg_next = bus_req.wdata[11:0];
            GPF_PPER_OFS: pper_next = wr_half;
            GPF_PDUT_OFS: pdut_next = wr_half;
            GPF_SPER_OFS: sper_next = wr_half;
            GPF_SDUTA_OFS: sduta_next = wr_half;
            GPF_SDUTB_OFS: sdutb_next = wr_half;
            GPF_IEN_OFS: ien_next = wr_pins;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dir_reg <= GPF_PINS_RST;
         out_reg <= GPF_PINS_RST;
         drv_reg <= GPF_PINS_RST;
         pen_reg <= GPF_PINS_RST;
         pup_reg <= GPF_PINS_RST;
         wen_reg <= GPF_PINS_RST;
         wlv_reg <= GPF_PINS_RST;
         psel_reg <= GPF_PINS_RST;
         sqcfg_reg <= GPF_SQCFG_RST;
         pper_reg <= GPF_PPER_RST;
         pdut_reg <= GPF_PDUT_RST;
         sper_reg <= GPF_SPER_RST;
         sduta_reg <= GPF_SDUT_RST;
         sdutb_reg <= GPF_SDUT_RST;
         ien_reg <= GPF_PINS_RST;
      end
      else
      begin
         dir_reg <= dir_next;
         out_reg <= out_next;
         drv_reg <= drv_next;
         pen_reg <= pen_next;
         pup_reg <= pup_next;
         wen_reg <= wen_next;
         wlv_reg <= wlv_next;
         psel_reg <= psel_next;
         sqcfg_reg <= sqcfg_next;
         pper_reg <= pper_next;
         pdut_reg <= pdut_next;
         sper_reg <= sper_next;
         sduta_reg <= sduta_next;
         sdutb_reg <= sdutb_next;
         ien_reg <= ien_next;
      end
   end

   // Wake status: a new hit in the clear cycle survives the clear
   always_comb
   begin
      istat_next = istat_reg;
      if (wr_hit && bus_req.addr == GPF_ICLR_OFS)
         istat_next = istat_reg & ~wr_pins;
      istat_next = istat_next | wake_hit;
      irq_next = |(istat_next & ien_reg);
      wake_next = |wake_hit;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         istat_reg <= GPF_PINS_RST;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
      end
      else
      begin
         istat_reg <= istat_next;
         irq_reg <= irq_next;
         wake_reg <= wake_next;
      end
   end

   // Read port; data stands for exactly the cycle after the strobe
   always_comb
   begin
      rdata_next = GPF_RDATA_RST;
      if (bus_req.rd)
      begin
         unique case (bus_req.addr)
            GPF_DIR_OFS: rdata_next = {13'h0000, dir_reg};
            GPF_OUT_OFS: rdata_next = {13'h0000, out_reg};
            GPF_IN_OFS: rdata_next = {13'h0000, pin_in};
            GPF_DRV_OFS: rdata_next = {13'h0000, drv_reg};
            GPF_PEN_OFS: rdata_next = {13'h0000, pen_reg};
            GPF_PUP_OFS: rdata_next = {13'h0000, pup_reg};
            GPF_WEN_OFS: rdata_next = {13'h0000, wen_reg};
            GPF_WLV_OFS: rdata_next = {13'h0000, wlv_reg};
            GPF_PSEL_OFS: rdata_next = {13'h0000, psel_reg};
            GPF_SQCFG_OFS: rdata_next = {20'h00000, sqcfg_reg};
            GPF_PPER_OFS: rdata_next = {16'h0000, pper_reg};
            GPF_PDUT_OFS: rdata_next = {16'h0000, pdut_reg};
            GPF_SPER_OFS: rdata_next = {16'h0000, sper_reg};
            GPF_SDUTA_OFS: rdata_next = {16'h0000, sduta_reg};
            GPF_SDUTB_OFS: rdata_next = {16'h0000, sdutb_reg};
            GPF_ISTAT_OFS: rdata_next = {13'h0000, istat_reg};
            GPF_IEN_OFS: rdata_next = {13'h0000, ien_reg};
            default: rdata_next = GPF_RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         rdata_reg <= GPF_RDATA_RST;
      else
         rdata_reg <= rdata_next;
   end

   // Pad drive; the pad stage adds one cycle so every pad is a flop output
   always_comb
   begin
      pad_next.oe = dir_reg;
      pad_next.out = pin_drv_val & dir_reg;
      pad_next.drive_high = drv_reg;
      pad_next.pull_en = pen_reg;
      pad_next.pull_up = pup_reg;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pad_reg.oe <= GPF_PINS_RST;
         pad_reg.out <= GPF_PINS_RST;
         pad_reg.drive_high <= GPF_PINS_RST;
         pad_reg.pull_en <= GPF_PINS_RST;
         pad_reg.pull_up <= GPF_PINS_RST;
      end
      else
         pad_reg <= pad_next;
   end

   assign rdata = rdata_reg;
   assign pad = pad_reg;
   assign wake = wake_reg;
   assign irq = irq_reg;
endmodule

// *** rtl/gpf_wave_gen.sv ***
`timescale 1ns/1ps
module gpf_wave_gen
#(
   parameter logic [15:0] MIN_PER = 16'h0001
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] period,
   input wire logic [15:0] duty,
   output logic wave
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic wave_reg;
   logic wave_next;
   logic [15:0] eff_per;

   always_comb
   begin
      // A period of zero stops the wave; short periods are held to the top rate
      if (period == 16'h0000)
         eff_per = 16'h0000;
      else if (period < MIN_PER)
         eff_per = MIN_PER;
      else
         eff_per = period;
      if (eff_per == 16'h0000 || cnt_reg >= eff_per - 16'h0001)
         cnt_next = 16'h0000;
      else
         cnt_next = cnt_reg + 16'h0001;
      // Ends of the duty span are static levels so no runt pulse slips out
      if (eff_per == 16'h0000 || duty == 16'h0000)
         wave_next = 1'b0;
      else if (duty >= eff_per)
         wave_next = 1'b1;
      else
         wave_next = (cnt_next < duty);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cnt_reg <= 16'h0000;
         wave_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         wave_reg <= wave_next;
      end
   end

   assign wave = wave_reg;
endmodule
